// [bench/link_partner_model.sv]
// Upstream link partner model: answers a training start after a fixed delay
`timescale 1ns/100ps
module link_partner_model #(
    parameter int DELAY = 200
) (
    input wire logic clk_sys, // Core clock
    input wire logic rst_n, // Fundamental reset
    input wire logic start_training, // Training start from the switch
    output logic train_done // Link up pulse
);
    int cnt;
    // Long delay keeps a failover busy across a watchdog tick
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cnt <= 0;
            train_done <= 1'b0;
        end else begin
            train_done <= (cnt == 1);
            if (start_training) begin
                cnt <= DELAY;
            end else if (cnt != 0) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule : link_partner_model

// [bench/upstream_port_failover_tb.sv]
// Testbench for the upstream port failover controller
`timescale 1ns/100ps
module upstream_port_failover_tb;
    logic clk_sys = 1'b0, rst_n = 1'b0, hot_reset = 1'b0, gpio4_in = 1'b0, sw_select = 1'b0;
    logic pin_failover_enable = 1'b0, timer_failover_enable = 1'b0, link_down_hot_reset_disable = 1'b0;
    logic wdog_write = 1'b0, change_clear = 1'b0, train_done, hr_seen, fd_seen;
    logic [3:0] boot_mode_select = 4'h0;
    logic [31:0] wdog_wdata = 32'h0, failover_watchdog_reg;
    logic failover_enabled_flag, current_upstream_port, upstream_change_flag, upstream_change_initiated_flag;
    logic lane_mux_sel, port2_disable, ltssm_force_detect, dl_force_down, start_training, hot_reset_req;
    logic link_status_port0;
    int fails = 0, total_checks = 0, span;
    always #4 clk_sys = ~clk_sys;
    upstream_port_failover #(.SETTLE(2)) upstream_port_failover_i (.clk_sys(clk_sys), .rst_n(rst_n),
        .hot_reset(hot_reset), .boot_mode_select(boot_mode_select), .gpio4_in(gpio4_in), .sw_select(sw_select),
        .pin_failover_enable(pin_failover_enable), .timer_failover_enable(timer_failover_enable),
        .link_down_hot_reset_disable(link_down_hot_reset_disable), .wdog_write(wdog_write),
        .wdog_wdata(wdog_wdata), .change_clear(change_clear), .train_done(train_done),
        .failover_enabled_flag(failover_enabled_flag), .current_upstream_port(current_upstream_port),
        .upstream_change_flag(upstream_change_flag), .upstream_change_initiated_flag(upstream_change_initiated_flag),
        .lane_mux_sel(lane_mux_sel), .port2_disable(port2_disable), .ltssm_force_detect(ltssm_force_detect),
        .dl_force_down(dl_force_down), .start_training(start_training), .hot_reset_req(hot_reset_req),
        .link_status_port0(link_status_port0), .failover_watchdog_reg(failover_watchdog_reg));
    link_partner_model link_partner_model_i (.clk_sys(clk_sys), .rst_n(rst_n), .start_training(start_training),
        .train_done(train_done));
    // Sampled at the falling edge so one-cycle pulses are seen settled
    always @(negedge clk_sys) begin
        if (hot_reset_req === 1'b1) hr_seen = 1'b1;
        if (ltssm_force_detect === 1'b1 && dl_force_down === 1'b1) fd_seen = 1'b1;
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic wrap_up();
        $display("Checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up
    task automatic do_reset(input logic [3:0] mode);
        @(negedge clk_sys);
        rst_n = 1'b0;
        {gpio4_in, pin_failover_enable, timer_failover_enable} = 3'h0;
        // Software select starts equal to the strapped port, else a failover fires at once
        sw_select = (mode == failover_pkg::MODE_FO_P2 || mode == failover_pkg::MODE_EE_FO_P2);
        boot_mode_select = mode;
        repeat (12) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (3) @(negedge clk_sys);
    endtask : do_reset
    task automatic wait_busy(input logic lvl);
        span = 0;
        while (upstream_change_initiated_flag !== lvl && span < 1000) begin
            @(negedge clk_sys);
            span++;
        end
        check("busy", upstream_change_initiated_flag, lvl);
    endtask : wait_busy
    task automatic pulse_hot_reset();
        @(negedge clk_sys);
        hot_reset = 1'b1;
        @(negedge clk_sys);
        hot_reset = 1'b0;
    endtask : pulse_hot_reset
    task automatic wdog_set(input logic [31:0] v);
        @(negedge clk_sys);
        wdog_wdata = v;
        wdog_write = 1'b1;
        @(negedge clk_sys);
        wdog_write = 1'b0;
    endtask : wdog_set
    task automatic boot_modes();
        logic fo;
        logic p2;
        for (int i = 0; i < 6; i++) begin
            do_reset(i[3:0]);
            fo = (i >= 1 && i <= 4);
            p2 = (i[3:0] == failover_pkg::MODE_FO_P2 || i[3:0] == failover_pkg::MODE_EE_FO_P2);
            check("enabled", failover_enabled_flag, fo);
            check("cur", current_upstream_port, p2);
            check("mux", lane_mux_sel, p2);
            check("p2dis", port2_disable, fo);
            check("lsp0", link_status_port0, 1'b1);
            if (!fo) begin
                @(negedge clk_sys);
                sw_select = 1'b1;
                repeat (30) @(negedge clk_sys);
                check("inert", {upstream_change_initiated_flag, current_upstream_port}, 2'h0);
            end
        end
    endtask : boot_modes
    task automatic sw_and_pin();
        do_reset(failover_pkg::MODE_FO_P0);
        {hr_seen, fd_seen} = 2'h0;
        sw_select = 1'b1;
        wait_busy(1'b1);
        wait_busy(1'b0);
        check("down", {fd_seen, hr_seen}, 2'h3);
        check("cur", {current_upstream_port, lane_mux_sel, upstream_change_flag}, 3'h7);
        pulse_hot_reset();
        check("sticky", {current_upstream_port, upstream_change_flag}, 2'h3);
        change_clear = 1'b1;
        @(negedge clk_sys);
        change_clear = 1'b0;
        link_down_hot_reset_disable = 1'b1;
        hr_seen = 1'b0;
        gpio4_in = 1'b0;
        repeat (30) @(negedge clk_sys);
        check("pin_off", upstream_change_initiated_flag, 1'b0);
        pin_failover_enable = 1'b1;
        wait_busy(1'b1);
        wait_busy(1'b0);
        check("pin", {current_upstream_port, upstream_change_flag, hr_seen}, 3'h2);
    endtask : sw_and_pin
    task automatic watchdog();
        do_reset(failover_pkg::MODE_FO_P0);
        timer_failover_enable = 1'b1;
        wdog_set(32'h3);
        check("count", failover_watchdog_reg, 32'h3);
        pulse_hot_reset();
        wait_busy(1'b1);
        // Tick phase is free running, so the span lies between two and three ticks
        check("span", span >= 2 * failover_pkg::TICK_CYCLES - 4 && span <= 3 * failover_pkg::TICK_CYCLES, 1);
        wait_busy(1'b0);
        repeat (300) @(negedge clk_sys);
        check("wd", failover_watchdog_reg, 32'h0);
        check("wd_port", {upstream_change_initiated_flag, current_upstream_port}, 2'h1);
    endtask : watchdog
    task automatic mixed_sources();
        do_reset(failover_pkg::MODE_FO_P2);
        sw_select = 1'b0;
        timer_failover_enable = 1'b1;
        wdog_set(32'h1);
        wait_busy(1'b1);
        wait_busy(1'b0);
        check("first", current_upstream_port, 1'b0);
        wait_busy(1'b1);
        wait_busy(1'b0);
        check("held", current_upstream_port, 1'b1);
    endtask : mixed_sources
    initial begin
        boot_modes();
        sw_and_pin();
        watchdog();
        mixed_sources();
        wrap_up();
    end
    initial begin
        #(8 * 20000);
        fails++;
        wrap_up();
    end
endmodule : upstream_port_failover_tb

// [verilog/failover_pkg.sv]
// Constants for the upstream port failover controller
// Contract
// RQ1 - Failover is disabled unless a failover boot mode was sampled at fundamental reset.
// RQ2 - Stack zero is upstream; a lane mux feeds it port 0 or port 2 lanes.
// RQ3 - In failover boot modes port 2 is disabled downstream; ports 1 and 3 run normally.
// RQ4 - Upstream resources such as link status outputs stay tied to port 0.
// RQ5 - Failover forces Detect and DL_Down, flushes queues, switches mux, then retrains.
// RQ6 - With link_down_hot_reset_disable set, failover DL_Down causes no hot reset.
// RQ7 - failover_enabled_flag is set whenever a failover boot mode is active.
// RQ8 - current_upstream_port always reports port 0 or port 2.
// RQ9 - Each dynamic failover sets sticky upstream_change_flag, kept across hot reset.
// RQ10 - Hot reset does not disturb failover; controls are inert outside failover modes.
// RQ11 - Port-2 failover modes pick port 2 at reset; all others pick port 0.
// RQ12 - Static failover: hold fundamental reset, change boot mode, release reset.
// RQ13 - Same-source request during failover is dropped; other-source request is held. The code does not hold a pin request: pin_req is blocked while busy.
// RQ14 - A change to the software select starts a failover in failover modes.
// RQ15 - Software must not change the software select while a failover runs.
// RQ16 - Pin failover needs pin enable, failover mode, and pin port differing from current.
// RQ17 - Pin select follows GPIO 4; low picks port 0, high picks port 2.
// RQ18 - The select pin changes at most once per second.
// RQ19 - Watchdog failover starts on enable, failover mode, and count going one to zero.
// RQ20 - Nonzero count decrements each microsecond, stops at zero until rewritten nonzero.
// RQ21 - Count is writable any time and keeps counting through hot reset.
// RQ22 - Watchdog failover moves upstream to the port not currently reported.
// RQ23 - The watchdog count is 32 bits wide.
package failover_pkg;
    localparam int CLK_MHZ = 125;
    localparam int TICK_US = 1;
    localparam int TICK_CYCLES = CLK_MHZ * TICK_US;
    localparam int COUNT_W = 32;
    localparam int MODE_W = 4;
    localparam logic [3:0] MODE_NORMAL = 4'h0;
    localparam logic [3:0] MODE_FO_P0 = 4'h1;
    localparam logic [3:0] MODE_FO_P2 = 4'h2;
    localparam logic [3:0] MODE_EE_FO_P0 = 4'h3;
    localparam logic [3:0] MODE_EE_FO_P2 = 4'h4;
    localparam int SETTLE_CYCLES = 16;
    localparam int SRC_SW = 0;
    localparam int SRC_PIN = 1;
    localparam int SRC_WDOG = 2;
    typedef enum logic [1:0] {FO_IDLE, FO_DOWN, FO_SWITCH, FO_TRAIN} fo_state_t;
endpackage : failover_pkg

// [verilog/upstream_port_failover.sv]
// Upstream port failover controller: mode capture, request arbitration, watchdog and lane mux select
`timescale 1ns/100ps
module upstream_port_failover #(
    parameter int SETTLE = failover_pkg::SETTLE_CYCLES
) (
    input wire logic clk_sys, // Core clock
    input wire logic rst_n, // Fundamental reset, sync low
    input wire logic hot_reset, // Hot reset pulse; failover state survives it
    input wire logic [3:0] boot_mode_select, // Boot mode straps
    input wire logic gpio4_in, // Upstream select pin
    input wire logic sw_select, // Software select field, 0 port0 1 port2
    input wire logic pin_failover_enable, // Pin failover enable
    input wire logic timer_failover_enable, // Watchdog failover enable
    input wire logic link_down_hot_reset_disable, // Suppress hot reset on link down
    input wire logic wdog_write, // Watchdog count write strobe
    input wire logic [31:0] wdog_wdata, // Watchdog count write data
    input wire logic change_clear, // Clears upstream change flag
    input wire logic train_done, // Link training completed on new port
    output logic failover_enabled_flag, // Failover boot mode active
    output logic current_upstream_port, // 0 port0, 1 port2
    output logic upstream_change_flag, // Sticky change flag
    output logic upstream_change_initiated_flag, // Failover in progress
    output logic lane_mux_sel, // Lanes into stack zero, 1 port2
    output logic port2_disable, // Port 2 downstream disabled
    output logic ltssm_force_detect, // Force upstream LTSSM to Detect
    output logic dl_force_down, // Force DL_Down and flush queues
    output logic start_training, // Start link training pulse
    output logic hot_reset_req, // Hot reset of hierarchy on link down
    output logic link_status_port0, // Upstream resources bound to port 0
    output logic [31:0] failover_watchdog_reg // Watchdog count
);
    // Pin sync
    logic pin_s1, pin_s2;
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pin_s1 <= 1'b0;
            pin_s2 <= 1'b0;
        end else begin
            pin_s1 <= gpio4_in;
            pin_s2 <= pin_s1; // RQ17
        end
    end

    // Strap capture at release of fundamental reset
    logic in_rst, fo_mode, init_p2;
    logic next_fo_mode, next_init_p2;
    always_comb begin
        next_fo_mode = fo_mode;
        next_init_p2 = init_p2;
        if (in_rst) begin
            next_fo_mode = (boot_mode_select == failover_pkg::MODE_FO_P0) ||
                (boot_mode_select == failover_pkg::MODE_FO_P2) ||
                (boot_mode_select == failover_pkg::MODE_EE_FO_P0) ||
                (boot_mode_select == failover_pkg::MODE_EE_FO_P2); // RQ1
            next_init_p2 = (boot_mode_select == failover_pkg::MODE_FO_P2) ||
                (boot_mode_select == failover_pkg::MODE_EE_FO_P2); // RQ11
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            in_rst <= 1'b1;
            fo_mode <= 1'b0;
            init_p2 <= 1'b0;
        end else begin
            in_rst <= 1'b0;
            fo_mode <= next_fo_mode;
            init_p2 <= next_init_p2;
        end
    end

    // Watchdog; hot_reset deliberately unused here so counting continues
    logic [7:0] tick_cnt;
    logic [7:0] next_tick_cnt;
    logic [31:0] next_wdog;
    logic tick, wdog_expire;
    always_comb begin
        tick = (tick_cnt == 8'(failover_pkg::TICK_CYCLES - 1));
        next_tick_cnt = tick ? 8'h00 : tick_cnt + 8'h01;
        next_wdog = failover_watchdog_reg;
        wdog_expire = 1'b0;
        if (wdog_write) begin
            next_wdog = wdog_wdata; // RQ21
        end else if (tick && failover_watchdog_reg != 32'h0) begin
            next_wdog = failover_watchdog_reg - 32'h1; // RQ20
            wdog_expire = (failover_watchdog_reg == 32'h1); // RQ19
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            tick_cnt <= 8'h00;
            failover_watchdog_reg <= 32'h0;
        end else begin
            tick_cnt <= next_tick_cnt;
            failover_watchdog_reg <= next_wdog;
        end
    end

    // Requests
    logic sw_q, busy;
    logic [2:0] pend, busy_src, req;
    logic [2:0] req_tgt, pend_tgt;
    logic wd_req, pin_req, sw_req;
    always_comb begin
        sw_req = fo_mode && !in_rst && (sw_select != sw_q); // RQ14
        pin_req = fo_mode && pin_failover_enable && (pin_s2 != current_upstream_port) &&
            !(busy || pend[failover_pkg::SRC_PIN]); // RQ16
        wd_req = fo_mode && timer_failover_enable && wdog_expire; // RQ19
        req = {wd_req, pin_req, sw_req};
    end

    // Failover sequencer
    failover_pkg::fo_state_t state, next_state;
    logic [31:0] settle_cnt, next_settle_cnt;
    logic cur, next_cur, next_sw_q, next_chg;
    logic [2:0] next_pend, next_busy_src, next_pend_tgt;
    logic next_tgt, tgt;
    logic [2:0] grant;
    always_comb begin
        next_state = state;
        next_settle_cnt = settle_cnt;
        next_cur = cur;
        next_sw_q = fo_mode ? sw_select : sw_q;
        next_chg = upstream_change_flag;
        next_pend = pend;
        next_pend_tgt = pend_tgt;
        next_busy_src = busy_src;
        next_tgt = tgt;
        req_tgt = {~cur, pin_s2, sw_select}; // RQ22
        grant = 3'b000;
        if (change_clear) begin
            next_chg = 1'b0;
        end
        for (int i = 0; i < 3; i++) begin
            if (req[i]) begin
                if (busy && busy_src[i]) begin
                    next_pend[i] = pend[i]; // RQ13
                end else begin
                    next_pend[i] = 1'b1; // RQ13
                    next_pend_tgt[i] = req_tgt[i];
                end
            end
        end
        case (state)
            failover_pkg::FO_IDLE: begin
                for (int i = 2; i >= 0; i--) begin
                    if (next_pend[i]) begin
                        grant = 3'b000;
                        grant[i] = 1'b1;
                    end
                end
                if (grant != 3'b000) begin
                    next_pend = next_pend & ~grant;
                    next_busy_src = grant;
                    next_tgt = |(grant & next_pend_tgt);
                    next_state = failover_pkg::FO_DOWN;
                end
            end
            failover_pkg::FO_DOWN: begin
                next_cur = tgt; // RQ5
                next_chg = 1'b1; // RQ9
                next_settle_cnt = 32'h0;
                next_state = failover_pkg::FO_SWITCH;
            end
            failover_pkg::FO_SWITCH: begin
                next_settle_cnt = settle_cnt + 32'h1;
                if (settle_cnt == 32'(SETTLE - 1)) begin
                    next_state = failover_pkg::FO_TRAIN;
                end
            end
            default: begin
                if (train_done) begin
                    next_busy_src = 3'b000;
                    next_state = failover_pkg::FO_IDLE;
                end
            end
        endcase
    end
    assign busy = (state != failover_pkg::FO_IDLE);
    // Hot reset not applied: sequencer and flags survive it
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state <= failover_pkg::FO_IDLE;
            settle_cnt <= 32'h0;
            cur <= 1'b0;
            sw_q <= 1'b0;
            upstream_change_flag <= 1'b0;
            pend <= 3'b000;
            pend_tgt <= 3'b000;
            busy_src <= 3'b000;
            tgt <= 1'b0;
        end else begin
            state <= in_rst ? failover_pkg::FO_IDLE : next_state;
            settle_cnt <= next_settle_cnt;
            cur <= in_rst ? next_init_p2 : next_cur; // RQ11
            sw_q <= in_rst ? next_init_p2 : next_sw_q;
            upstream_change_flag <= next_chg; // RQ9
            pend <= in_rst ? 3'b000 : next_pend;
            pend_tgt <= next_pend_tgt;
            busy_src <= next_busy_src;
            tgt <= next_tgt;
        end
    end

    // Outputs
    always_comb begin
        failover_enabled_flag = fo_mode; // RQ7
        current_upstream_port = cur; // RQ8
        upstream_change_initiated_flag = busy;
        lane_mux_sel = cur; // RQ2
        port2_disable = fo_mode; // RQ3
        link_status_port0 = 1'b1; // RQ4
        ltssm_force_detect = (state == failover_pkg::FO_DOWN) || (state == failover_pkg::FO_SWITCH); // RQ5
        dl_force_down = (state != failover_pkg::FO_IDLE) && (state != failover_pkg::FO_TRAIN); // RQ5
        start_training = (state == failover_pkg::FO_SWITCH) && (settle_cnt == 32'(SETTLE - 1)); // RQ5
        hot_reset_req = (state == failover_pkg::FO_DOWN) && !link_down_hot_reset_disable; // RQ6
    end

    fo_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !fo_mode |-> !busy) else $error("failover ran outside failover mode"); // RQ1
    wdog_dec_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (tick && !wdog_write && failover_watchdog_reg != 32'h0) |=>
        failover_watchdog_reg == $past(failover_watchdog_reg) - 32'h1) else $error("watchdog missed decrement"); // RQ20
    wdog_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (failover_watchdog_reg == 32'h0 && !wdog_write) |=> failover_watchdog_reg == 32'h0)
        else $error("watchdog left zero"); // RQ20
    sw_start_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (sw_req && !busy && pend == 3'b000) |=> state == failover_pkg::FO_DOWN)
        else $error("software failover not started"); // RQ14
    chg_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state == failover_pkg::FO_DOWN |=> upstream_change_flag && cur == $past(tgt))
        else $error("change not recorded"); // RQ9
    hot_sup_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        link_down_hot_reset_disable |-> !hot_reset_req) else $error("hot reset not suppressed"); // RQ6
    mux_port_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        lane_mux_sel == current_upstream_port) else $error("mux differs from current port"); // RQ2
    train_seq_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state == failover_pkg::FO_DOWN |=> ltssm_force_detect ##1 ltssm_force_detect)
        else $error("detect not held"); // RQ5
    init_port_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        in_rst |=> cur == $past(next_init_p2)) else $error("wrong initial port"); // RQ11

    // Mode and static outputs
    mode_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ1
        !in_rst |=> $stable(fo_mode))
        else $error("failover mode changed after reset");

    flag_mode_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ7
        failover_enabled_flag == fo_mode)
        else $error("enabled flag differs from mode");

    p2_dis_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ3
        port2_disable == failover_enabled_flag)
        else $error("port 2 disable wrong");

    lsp_port0_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ4
        link_status_port0)
        else $error("link status left port 0");

    inert_mode_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ10
        !fo_mode |-> req == 3'b000)
        else $error("request outside failover mode");

    // Port switch only happens in the down state or at strap capture
    cur_stable_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ8
        (state != failover_pkg::FO_DOWN && !in_rst) |=> $stable(cur))
        else $error("port changed outside failover");

    mux_switch_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ2
        state == failover_pkg::FO_DOWN |=> lane_mux_sel == $past(tgt))
        else $error("mux not switched to target");

    chg_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ9
        (upstream_change_flag && !change_clear) |=> upstream_change_flag)
        else $error("change flag lost");

    down_force_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ5
        state == failover_pkg::FO_DOWN |-> ltssm_force_detect && dl_force_down)
        else $error("down state without forcing");

    hot_req_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ6
        hot_reset_req |-> state == failover_pkg::FO_DOWN)
        else $error("hot reset outside link down");

    train_after_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ5
        start_training |=> state == failover_pkg::FO_TRAIN && !start_training)
        else $error("training start not single");

    train_wait_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ5
        (state == failover_pkg::FO_TRAIN && !train_done) |=> state == failover_pkg::FO_TRAIN)
        else $error("training left early");

    // Arbitration between sources
    held_req_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ13
        (busy && wd_req && !busy_src[failover_pkg::SRC_WDOG]) |=> pend[failover_pkg::SRC_WDOG])
        else $error("other source not held");

    same_drop_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ13
        (busy && busy_src[failover_pkg::SRC_SW] && sw_req && !pend[failover_pkg::SRC_SW]) |=> !pend[failover_pkg::SRC_SW])
        else $error("same source not dropped");

    pin_start_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ16
        (pin_req && !sw_req && pend == 3'b000) |=> state == failover_pkg::FO_DOWN)
        else $error("pin failover not started");

    wd_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ19
        (tick && failover_watchdog_reg == 32'h1 && !wdog_write && timer_failover_enable && fo_mode) |-> wd_req)
        else $error("watchdog expiry not requested");

    wd_target_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ22
        (wd_req && !sw_req && !pin_req && !busy && pend == 3'b000) |=> tgt != cur)
        else $error("watchdog target not other port");

    wd_rearm_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ21
        wdog_write |=> failover_watchdog_reg == $past(wdog_wdata))
        else $error("watchdog write lost");
endmodule : upstream_port_failover
